/* File: dcrb_pkg.sv */
// register map, field layout, reset values and timing counts of the
// device control register bank.
// assumes a single 20 MHz core clock shared by every user of the package.
package dcrb_pkg;

	// ****************************************************************
	// bus and map
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// printed offsets are register indices; byte address is four times
	localparam logic [1:0] IDX_WATCHDOG_CONTROL = 2'h0;
	localparam logic [1:0] IDX_POWER_CLOCK_CONTROL = 2'h1;
	localparam logic [1:0] IDX_SLEEP_REQUEST_CONTROL = 2'h2;
	localparam logic [1:0] IDX_MONITOR_STATUS = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int WDOG_EN_POS = 7;
	localparam int TIMEOUT_LSB = 0;
	localparam int SLEEP_PERMIT_POS = 7;
	localparam int AUX_REG_EN_POS = 6;
	localparam int SECOND_CONV_EN_POS = 5;
	localparam int CLKOUT_EN_POS = 4;
	localparam int CLKOUT_RATE_POS = 3;
	localparam int SLEEP_REQ_POS = 7;
	localparam int PREV_SLEEP_POS = 7;
	localparam logic [7:0] WATCHDOG_CONTROL_RST = 8'h0F;
	localparam logic [7:0] POWER_CLOCK_CONTROL_RST = 8'h70;
	localparam logic [7:0] SLEEP_REQUEST_CONTROL_RST = 8'h00;
	localparam logic [7:0] MONITOR_STATUS_RST = 8'h00;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int MS_TICK_NS = 1000000;
	localparam int MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
	// watchdog period in ms for each timeout code 0..15
	localparam logic [9:0] WDOG_PERIOD_MS [16] = '{
		10'h021, 10'h042, 10'h062, 10'h083, 10'h0A4, 10'h0C5, 10'h0E5, 10'h106,
		10'h127, 10'h148, 10'h168, 10'h189, 10'h1AA, 10'h1CB, 10'h1EC, 10'h20C
	};

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic aux_rail_good;
		logic second_rail_good;
		logic bus_voltage_good;
		logic filter_voltage_good;
		logic crystal_running;
		logic thermal_warning;
		logic thermal_shutdown_seen;
	} dcrb_monitor_s;

	typedef struct packed {
		logic sleep_permit;
		logic aux_regulator_enable;
		logic second_converter_enable;
		logic clock_output_enable;
		logic clock_output_rate_select;
	} dcrb_power_clock_s;

	typedef enum logic [1:0] {
		WR_COLLECT = 2'b01,
		WR_RESP = 2'b10
	} dcrb_wr_state_e;

endpackage

/* File: dcrb_watchdog.sv */
// watchdog timer of the device control register bank.
// assumes enable, kick and timeout code come from registers on the same clock.
`timescale 1ns/1ps
module dcrb_watchdog
	import dcrb_pkg::*;
#(
	parameter int MS_CYCLES = MS_TICK_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic enable,
	input wire logic kick,
	input wire logic [3:0] timeout_select,
	// event
	output logic expired
);

	logic [15:0] div_reg;
	logic [9:0] ms_reg;
	logic tick;

	// ****************************************************************
	// millisecond tick
	// ****************************************************************
	assign tick = (div_reg == 16'(MS_CYCLES - 1));

	// divider restarts with each kick so a kick gives a full period
	always_ff @(posedge aclk) begin
		if (!aresetn || !enable || kick || tick) begin
			div_reg <= 16'h0000;
		end else begin
			div_reg <= div_reg + 16'h0001;
		end
	end

	// ****************************************************************
	// period count and event
	// ****************************************************************
	// elapsed ms since last kick; rolls over after each event
	always_ff @(posedge aclk) begin
		if (!aresetn || !enable || kick) begin
			ms_reg <= 10'h000;
		end else if (tick) begin
			if (ms_reg == WDOG_PERIOD_MS[timeout_select] - 10'h001) begin
				ms_reg <= 10'h000;
			end else begin
				ms_reg <= ms_reg + 10'h001;
			end
		end
	end

	// one-cycle pulse when the selected period runs out unrefreshed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			expired <= 1'b0;
		end else begin
			expired <= enable && !kick && tick &&
				(ms_reg == WDOG_PERIOD_MS[timeout_select] - 10'h001);
		end
	end

endmodule

/* File: dcrb_top.sv */
// device control register bank: watchdog, power and clock enables,
// guarded sleep request and monitor status, behind an AXI4-Lite slave.
// assumes monitor and wake pins are asynchronous; everything else on aclk.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module dcrb_top
	import dcrb_pkg::*;
#(
	parameter int MS_CYCLES = MS_TICK_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// axi4-lite read data
	output logic [DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// analog monitors and wake pin, asynchronous
	input wire dcrb_monitor_s monitor_in,
	input wire logic resume_event_pin,
	// power and clock controls, sleep state and watchdog event
	output logic aux_regulator_enable,
	output logic second_converter_enable,
	output logic clock_output_enable,
	output logic clock_output_rate_select,
	output logic sleep_mode,
	output logic watchdog_event
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	dcrb_wr_state_e wr_state_reg;
	logic aw_got_reg;
	logic w_got_reg;
	logic [ADDR_W-1:0] waddr_reg;
	logic [7:0] wbyte_reg;
	logic wlane_reg;
	logic do_write;
	logic wr_hit;
	logic [1:0] wr_idx;
	logic wdog_en_reg;
	logic [3:0] timeout_select_reg;
	dcrb_power_clock_s pcc_reg;
	logic sleep_request_reg;
	logic prev_sleep_reg;
	logic wdog_kick;
	dcrb_monitor_s mon_meta_reg;
	dcrb_monitor_s mon_sync_reg;
	logic wake_meta_reg;
	logic wake_sync_reg;
	logic wake_last_reg;
	logic wake_event;

	// ****************************************************************
	// address decode
	// ****************************************************************
	// a word address is mapped when it is one of the four indices
	function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
		return addr[ADDR_W-1:4] == '0;
	endfunction

	function automatic logic [1:0] addr_index(input logic [ADDR_W-1:0] addr);
		return addr[3:2];
	endfunction

	// ****************************************************************
	// write channel
	// ****************************************************************
	// write fires once both halves are held, in whichever order they came
	assign do_write = (wr_state_reg == WR_COLLECT) && aw_got_reg && w_got_reg;
	assign wr_idx = addr_index(waddr_reg);
	assign wr_hit = do_write && addr_mapped(waddr_reg) && wlane_reg;
	assign wdog_kick = wr_hit && (wr_idx == IDX_WATCHDOG_CONTROL) && wbyte_reg[WDOG_EN_POS];

	// write sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_reg <= WR_COLLECT;
		end else begin
			unique case (wr_state_reg)
				WR_COLLECT: begin
					if (do_write) begin
						wr_state_reg <= WR_RESP;
					end
				end
				WR_RESP: begin
					if (bready) begin
						wr_state_reg <= WR_COLLECT;
					end
				end
			endcase
		end
	end

	// address half; ready drops once taken until the response completes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			awready <= 1'b0;
			waddr_reg <= '0;
		end else if (awvalid && awready) begin
			aw_got_reg <= 1'b1;
			awready <= 1'b0;
			waddr_reg <= awaddr;
		end else if (wr_state_reg == WR_RESP && bready) begin
			aw_got_reg <= 1'b0;
			awready <= 1'b1;
		end else if (wr_state_reg == WR_COLLECT && !aw_got_reg) begin
			awready <= 1'b1;
		end
	end

	// data half; only byte lane 0 carries register bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_reg <= 1'b0;
			wready <= 1'b0;
			wbyte_reg <= 8'h00;
			wlane_reg <= 1'b0;
		end else if (wvalid && wready) begin
			w_got_reg <= 1'b1;
			wready <= 1'b0;
			wbyte_reg <= wdata[7:0];
			wlane_reg <= wstrb[0];
		end else if (wr_state_reg == WR_RESP && bready) begin
			w_got_reg <= 1'b0;
			wready <= 1'b1;
		end else if (wr_state_reg == WR_COLLECT && !w_got_reg) begin
			wready <= 1'b1;
		end
	end

	// response; unmapped writes are refused with slverr, status write is ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= addr_mapped(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// ****************************************************************
	// control registers
	// ****************************************************************
	// watchdog control; reserved bits 6..4 are not stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdog_en_reg <= WATCHDOG_CONTROL_RST[WDOG_EN_POS];
			timeout_select_reg <= WATCHDOG_CONTROL_RST[TIMEOUT_LSB+:4];
		end else if (wr_hit && wr_idx == IDX_WATCHDOG_CONTROL) begin
			wdog_en_reg <= wbyte_reg[WDOG_EN_POS];
			timeout_select_reg <= wbyte_reg[TIMEOUT_LSB+:4];
		end
	end

	// power and clock control; bits 2..0 dropped as reserved
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pcc_reg <= POWER_CLOCK_CONTROL_RST[7:3];
		end else if (wr_hit && wr_idx == IDX_POWER_CLOCK_CONTROL) begin
			pcc_reg <= wbyte_reg[7:3];
		end
	end

	// drive pins straight from the stored fields
	assign aux_regulator_enable = pcc_reg.aux_regulator_enable;
	assign second_converter_enable = pcc_reg.second_converter_enable;
	assign clock_output_enable = pcc_reg.clock_output_enable;
	assign clock_output_rate_select = pcc_reg.clock_output_rate_select;

	// sleep request bit; a wake clears it so the next entry needs a fresh write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_request_reg <= SLEEP_REQUEST_CONTROL_RST[SLEEP_REQ_POS];
		end else if (wr_hit && wr_idx == IDX_SLEEP_REQUEST_CONTROL) begin
			sleep_request_reg <= wbyte_reg[SLEEP_REQ_POS];
		end else if (sleep_mode && wake_event) begin
			sleep_request_reg <= 1'b0;
		end
	end

	// ****************************************************************
	// sleep mode
	// ****************************************************************
	// entry needs the permit already set; the permit alone does nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_mode <= 1'b0;
		end else if (!sleep_mode) begin
			if (wr_hit && wr_idx == IDX_SLEEP_REQUEST_CONTROL &&
				wbyte_reg[SLEEP_REQ_POS] && pcc_reg.sleep_permit) begin
				sleep_mode <= 1'b1;
			end
		end else if (wake_event) begin
			sleep_mode <= 1'b0;
		end
	end

	// remembers that the device has been asleep, until the next reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_sleep_reg <= MONITOR_STATUS_RST[PREV_SLEEP_POS];
		end else if (sleep_mode && wake_event) begin
			prev_sleep_reg <= 1'b1;
		end
	end

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	// two flops per pin; the edge detector reads the second and a third flop holding its delayed copy
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mon_meta_reg <= '0;
			mon_sync_reg <= '0;
			wake_meta_reg <= 1'b0;
			wake_sync_reg <= 1'b0;
			wake_last_reg <= 1'b0;
		end else begin
			mon_meta_reg <= monitor_in;
			mon_sync_reg <= mon_meta_reg;
			wake_meta_reg <= resume_event_pin;
			wake_sync_reg <= wake_meta_reg;
			wake_last_reg <= wake_sync_reg;
		end
	end

	// rising edge, so a pin held high does not cancel the next sleep
	assign wake_event = wake_sync_reg && !wake_last_reg;

	// ****************************************************************
	// watchdog
	// ****************************************************************
	dcrb_watchdog #(
		.MS_CYCLES(MS_CYCLES)
	) u_watchdog (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(wdog_en_reg),
		.kick(wdog_kick),
		.timeout_select(timeout_select_reg),
		.expired(watchdog_event)
	);

	// ****************************************************************
	// read channel
	// ****************************************************************
	// read data is sampled at the address handshake; no read changes state
	function automatic logic [7:0] read_byte(input logic [1:0] idx);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			IDX_WATCHDOG_CONTROL: begin
				v[WDOG_EN_POS] = wdog_en_reg;
				v[TIMEOUT_LSB+:4] = timeout_select_reg;
			end
			IDX_POWER_CLOCK_CONTROL: begin
				v[7:3] = pcc_reg;
			end
			IDX_SLEEP_REQUEST_CONTROL: begin
				v[SLEEP_REQ_POS] = sleep_request_reg;
			end
			IDX_MONITOR_STATUS: begin
				v = {prev_sleep_reg, mon_sync_reg};
			end
		endcase
		return v;
	endfunction

	// one read in flight; arready returns once the data is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
		end else if (!rvalid || rready) begin
			arready <= 1'b1;
		end
	end

	// answer the cycle after the handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= {24'h000000, addr_mapped(araddr) ? read_byte(addr_index(araddr)) : 8'h00};
			rresp <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

endmodule

/* File: dcrb_top_chk.sv */
// checker of the register bank: bus answers, sleep entry and exit, enables, watchdog pulse.
// assumes it is bound to dcrb_top and sees only that module's ports.
`timescale 1ns/1ps
module dcrb_top_chk
	import dcrb_pkg::*;
#(
	parameter int MS_CYCLES = MS_TICK_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	// pins
	input wire logic resume_event_pin,
	input wire logic aux_regulator_enable,
	input wire logic second_converter_enable,
	input wire logic clock_output_enable,
	input wire logic clock_output_rate_select,
	input wire logic sleep_mode,
	input wire logic watchdog_event
);
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// both write channels taken in one cycle
	sequence s_wr_both;
		awvalid && awready && wvalid && wready;
	endsequence
	// response offered but not yet taken
	sequence s_resp_held;
		bvalid && !bready;
	endsequence

	a_write_answer: assert property (s_wr_both |-> ##1 !awready ##1 bvalid)
		else $error("write response missing");
	a_resp_stands: assert property (s_resp_held |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer missing");
	a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data changed while held");
	a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_sleep_on_write: assert property ($rose(sleep_mode) |-> $rose(bvalid))
		else $error("sleep entered without a write");
	a_wake_only_pin: assert property ($fell(sleep_mode) |->
		$past(resume_event_pin, 2) || $past(resume_event_pin, 3))
		else $error("sleep left without wake pin");
	a_ctrl_on_write: assert property (!$stable({aux_regulator_enable,
		second_converter_enable, clock_output_enable,
		clock_output_rate_select}) |-> $rose(bvalid))
		else $error("enable changed without a write");
	a_event_pulse: assert property (watchdog_event |=> !watchdog_event [*8])
		else $error("watchdog event not a single pulse");
endmodule

bind dcrb_top dcrb_top_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
	.bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rresp(rresp), .rvalid(rvalid), .rready(rready), .resume_event_pin(resume_event_pin),
	.aux_regulator_enable(aux_regulator_enable),
	.second_converter_enable(second_converter_enable),
	.clock_output_enable(clock_output_enable),
	.clock_output_rate_select(clock_output_rate_select), .sleep_mode(sleep_mode),
	.watchdog_event(watchdog_event));

/* File: tb_top.sv */
// self-checking bench of the register bank: axi4-lite master tasks, a reference model in
// arrays, xorshift traffic. assumes dcrb_pkg and the checker are compiled before it.
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_top
	import dcrb_pkg::*;
;
	localparam int MSC = 4;
	// ****************************************
	// signals and model state
	// ****************************************
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	dcrb_monitor_s monitor_in = '0;
	logic resume_event_pin = 1'b0;
	logic aux_en, conv_en, clk_en, rate_sel, sleep_mode, watchdog_event;
	logic [31:0] seed = 32'h4496;
	logic [7:0] mreg [4] = '{8'h0F, 8'h70, 8'h00, 8'h00};
	logic msleep = 1'b0;
	logic mprev = 1'b0;
	int error_cnt = 0;
	int checked = 0;

	always #25 aclk = ~aclk;

	dcrb_top #(.MS_CYCLES(MSC)) i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .monitor_in(monitor_in),
		.resume_event_pin(resume_event_pin), .aux_regulator_enable(aux_en),
		.second_converter_enable(conv_en), .clock_output_enable(clk_en),
		.clock_output_rate_select(rate_sel), .sleep_mode(sleep_mode),
		.watchdog_event(watchdog_event));

	// ****************************************
	// tasks
	// ****************************************
	function automatic logic [31:0] nxt();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic results();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// a wait that ran out counts as a mismatch and ends the run
	task automatic bound(input int i);
		if (i >= 60) begin
			error_cnt++;
			$display("unexpected at %0t: wait count %h limit %h", $time, i, 60);
			results();
		end
	endtask

	// offers address and data together; bready rises after a random pause of 0 to 3 cycles, so for pauses of 2 or 3
	// the slave must hold its response, then stays up until the answer
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s);
		logic [1:0] er;
		int i;
		int dly;
		er = (a[7:4] != 4'h0) ? RESP_SLVERR : RESP_OKAY;
		dly = int'(nxt() % 32'd4);
		// one edge between transfers so no handshake signal is set twice in a step
		@(posedge aclk);
		awaddr <= a;
		wdata <= {seed[23:0], d};
		wstrb <= {seed[2:0], s};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (i = 0; i < 60; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
			if (i == dly) bready <= 1'b1;
		end
		bound(i);
		bready <= 1'b0;
		`CHK(bresp, er)
		if (er == RESP_OKAY && s) begin
			case (a[3:2])
				2'h0: mreg[0] = d & 8'h8F;
				2'h1: mreg[1] = d & 8'hF8;
				2'h2: begin
					mreg[2] = d & 8'h80;
					if (d[7] && mreg[1][7]) msleep = 1'b1;
				end
				default: ;
			endcase
		end
		`CHK({aux_en, conv_en, clk_en, rate_sel}, mreg[1][6:3])
		`CHK(sleep_mode, msleep)
	endtask

	// read; rready rises after a random pause of 0 to 3 cycles, so for pauses of 1 or more the slave must hold its data
	task automatic rd(input logic [7:0] a);
		int i;
		int dly;
		dly = int'(nxt() % 32'd4);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		for (i = 0; i < 60; i++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			if (i == dly) rready <= 1'b1;
		end
		bound(i);
		rready <= 1'b0;
		mreg[3] = {mprev, monitor_in};
		if (a[7:4] != 4'h0) begin
			`CHK({rresp, rdata}, {RESP_SLVERR, 32'h0})
		end else begin
			`CHK({rresp, rdata}, {RESP_OKAY, 24'h0, mreg[a[3:2]]})
		end
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		int k, i, p;
		logic [31:0] r;
		logic [7:0] a, d;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (k = 0; k < 4; k++) rd(8'(k * 4));
		$display("test reset values done");
		// watchdog and sleep permit kept off so random traffic stays quiet
		for (k = 0; k < 30; k++) begin
			r = nxt();
			a = r[4] ? (r[15:8] & 8'hFC) : {4'h0, r[3:2], 2'b00};
			d = r[23:16];
			if (a == 8'h00 || a == 8'h04) d[7] = 1'b0;
			wr(a, d, r[5] | r[6]);
			rd(a);
		end
		$display("test random access done");
		for (k = 0; k < 4; k++) begin
			r = nxt();
			monitor_in <= dcrb_monitor_s'(r[6:0]);
			repeat (4) @(posedge aclk);
			wr(8'h0C, r[15:8], 1'b1);
			rd(8'h0C);
		end
		$display("test status done");
		wr(8'h08, 8'h80, 1'b1);
		wr(8'h04, 8'hF0, 1'b1);
		wr(8'h08, 8'h80, 1'b1);
		wr(8'h08, 8'h00, 1'b1);
		rd(8'h04);
		resume_event_pin <= 1'b1;
		repeat (5) @(posedge aclk);
		resume_event_pin <= 1'b0;
		repeat (3) @(posedge aclk);
		msleep = 1'b0;
		mprev = 1'b1;
		mreg[2] = 8'h00;
		`CHK(sleep_mode, 1'b0)
		rd(8'h08);
		rd(8'h0C);
		$display("test sleep done");
		for (k = 0; k < 2; k++) begin
			p = k ? 524 : 33;
			wr(8'h00, k ? 8'h8F : 8'h80, 1'b1);
			for (i = 0; i < p * MSC + 10 && !watchdog_event; i++) @(posedge aclk);
			`CHK(i > p * MSC - 4 && i < p * MSC + 4, 1'b1)
		end
		// refreshed well inside the shortest period, so no event may appear
		wr(8'h00, 8'h80, 1'b1);
		for (k = 0; k < 300; k++) begin
			@(posedge aclk);
			`CHK(watchdog_event, 1'b0)
			if (k % 100 == 99) wr(8'h00, 8'h80, 1'b1);
		end
		wr(8'h00, 8'h00, 1'b1);
		for (k = 0; k < 300; k++) begin
			@(posedge aclk);
			`CHK(watchdog_event, 1'b0)
		end
		$display("test watchdog done");
		results();
	end
endmodule
